// ===== psrf_regs.vh
`ifndef PSRF_REGS_VH
`define PSRF_REGS_VH

// Register addresses
`define PSRF_AREA_ADDR      20'h0FFCD
`define PSRF_MODE_ADDR      20'h0FFCC

// Reset values
`define PSRF_MODE_RST       8'h00
`define PSRF_AREA_RST       8'h00

// Mode register fields
`define PSRF_INT_LO         0
`define PSRF_INT_HI         1
`define PSRF_EN_BIT         4
`define PSRF_LV_BIT         7
`define PSRF_MODE_WMASK     8'h93

// Interval select codes and terminal counts (interval length in clocks minus one)
`define PSRF_SEL_32         2'b00
`define PSRF_SEL_64         2'b01
`define PSRF_SEL_128        2'b10
`define PSRF_CNT_32         8'h1F
`define PSRF_CNT_64         8'h3F
`define PSRF_CNT_128        8'h7F

// Refresh bus cycle length in clocks
`define PSRF_CYC_LEN        2'h2

// Area block boundaries (upper address bits 15..10)
`define PSRF_BLK1           6'h01
`define PSRF_BLK2           6'h02
`define PSRF_BLK3           6'h03
`define PSRF_BLK4           6'h04
`define PSRF_BLK5           6'h08
`define PSRF_BLK6           6'h10
`define PSRF_BLK7           6'h20

`endif

// ===== psrf_interval.v
`timescale 1ns/1ps
`include "psrf_regs.vh"
`default_nettype none

// Free-running refresh interval counter with selectable period
module psrf_interval
(
	// Clock and reset
	input  wire       mclk,
	input  wire       rst,
	// Control
	input  wire       enable,
	input  wire       restart,
	input  wire [1:0] sel,
	// Status
	output reg        expired_ff
);

	reg  [7:0] cnt_ff;
	reg  [7:0] limit;
	wire [7:0] nxt_cnt;

	// Period from interval select
	always @*
	begin
		case (sel)
			`PSRF_SEL_128: limit = `PSRF_CNT_128;
			`PSRF_SEL_64:  limit = `PSRF_CNT_64;
			default:       limit = `PSRF_CNT_32;
		endcase
	end

	assign nxt_cnt = (!enable || restart || cnt_ff >= limit) ?
		8'h00 : cnt_ff + 8'h01;

	// Counter and one-cycle expiry pulse
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cnt_ff     <= 8'h00;
			expired_ff <= 1'b0;
		end
		else
		begin
			cnt_ff     <= nxt_cnt;
			expired_ff <= enable && !restart && (cnt_ff >= limit);
		end
	end

endmodule

`default_nettype wire

// ===== psrf_refresh.v
`timescale 1ns/1ps
`include "psrf_regs.vh"
`default_nettype none

// Functional notes
// R01 - Refresh pulses come out at an interval set in the mode register.
// R02 - Reset clears the mode register; the pin returns to port use.
// R03 - Mode register is eight bits, byte and bit writable and readable.
// R04 - Software keeps refresh off whenever bus hold is used.
// R05 - Area register is eight bits at 0FFCDH, reset to zero.
// R06 - Each area bit covers one address block from 00000 to 08000.
// R07 - Pulse refresh pulses are synchronised to bus cycles.
// R08 - Software picks clock and interval for 512 pulses per 8 ms.
// R09 - Interval codes give 128, 64 or 32 clocks.
// R10 - Refresh cycles and external accesses never overlap; each waits.
// R11 - Non-colliding refresh cycles do not stall the processor.
// R12 - Refresh cycles continue while only internal memory is used.
// R13 - Access to a clear-bit area pulses refresh with the strobe.
// R14 - After a pulse, a refresh cycle is inserted when the interval elapses.
// R15 - Enable one with level zero drives the pin low for self-refresh.
// R16 - Leaving self-refresh raises the pin aligned to the interval counter.
// R17 - Level bit reads one once the pin has actually risen.
// R18 - Refresh disabled means no cycles, no pulses, pin under port control; a cycle in progress still runs to its end with the pin in refresh mode.
module psrf_refresh
(
	// Clock and reset
	input  wire        mclk,
	input  wire        rst,
	// Register access
	input  wire [19:0] reg_addr,
	input  wire        reg_wr,
	input  wire        reg_bit_wr,
	input  wire [2:0]  reg_bit_sel,
	input  wire        reg_bit_val,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata_ff,
	// External bus access
	input  wire        ext_req,
	input  wire [19:0] ext_addr,
	input  wire        ext_strobe,
	output reg         ext_grant_ff,
	// Refresh pin and shared port
	output reg         refresh_request_pin_n_ff,
	output reg         refresh_pin_mode_ff,
	output reg         refresh_busy_ff
);

	// State codes
	// Idle waits for a due refresh or a self-refresh request.
	// A refresh bus cycle holds the pin low for a fixed length.
	// Self-refresh holds the pin low until the level bit is written one or refresh is disabled.
	// Exit keeps the pin low until the interval counter expires or refresh is
	// disabled, so that the first pulse after the rise lies a whole interval away.
	// Any other code falls back to idle.
	localparam ST_IDLE = 2'h0;
	localparam ST_CYC  = 2'h1;
	localparam ST_SELF = 2'h2;
	localparam ST_EXIT = 2'h3;

	reg  [7:0] refresh_mode_control_ff;
	reg  [7:0] refresh_area_select_ff;
	reg  [7:0] nxt_mode;
	reg  [7:0] nxt_area;
	reg  [1:0] state_ff;
	reg  [1:0] nxt_state;
	reg  [1:0] cyc_cnt_ff;
	reg        pend_ff;
	reg        level_ff;
	reg  [7:0] area_hit;
	wire       refresh_on_bit;
	wire       refresh_pin_level_bit;
	wire [1:0] sel;
	wire       expired;
	wire       area_simultaneous_bit;
	wire       sim_pulse;
	wire       mode_hit;
	wire       area_hit_reg;
	wire       interval_restart;

	// Mode register fields and register address decode
	assign refresh_on_bit        = refresh_mode_control_ff[`PSRF_EN_BIT];
	assign refresh_pin_level_bit = refresh_mode_control_ff[`PSRF_LV_BIT];
	assign sel = {refresh_mode_control_ff[`PSRF_INT_HI],
		refresh_mode_control_ff[`PSRF_INT_LO]};
	assign mode_hit     = (reg_addr == `PSRF_MODE_ADDR);
	assign area_hit_reg = (reg_addr == `PSRF_AREA_ADDR);

	////////////////////////////////////////////////////////////////////////
	// Address block decode for simultaneous refresh
	// Only the first 64 Kbytes are split into area blocks; higher
	// addresses never get a refresh pulse with the strobe
	always @*
	begin
		area_hit = 8'h00;
		if (ext_addr[19:16] == 4'h0) // R06
		begin
			if (ext_addr[15:10] >= `PSRF_BLK7)
				area_hit[7] = 1'b1;
			else if (ext_addr[15:10] >= `PSRF_BLK6)
				area_hit[6] = 1'b1;
			else if (ext_addr[15:10] >= `PSRF_BLK5)
				area_hit[5] = 1'b1;
			else if (ext_addr[15:10] >= `PSRF_BLK4)
				area_hit[4] = 1'b1;
			else if (ext_addr[15:10] >= `PSRF_BLK3)
				area_hit[3] = 1'b1;
			else if (ext_addr[15:10] >= `PSRF_BLK2)
				area_hit[2] = 1'b1;
			else if (ext_addr[15:10] >= `PSRF_BLK1)
				area_hit[1] = 1'b1;
			else
				area_hit[0] = 1'b1;
		end
	end

	// Clear bit in a decoded block allows a pulse with the strobe
	assign area_simultaneous_bit = |(area_hit & refresh_area_select_ff);
	assign sim_pulse = refresh_on_bit && refresh_pin_level_bit &&
		ext_strobe && (ext_addr[19:16] == 4'h0) &&
		!area_simultaneous_bit; // R13

	////////////////////////////////////////////////////////////////////////
	// Only a strobe pulse restarts the count; the exit from
	// self-refresh must follow the free-running beat, not hold it back
	assign interval_restart = sim_pulse; // R14

	// Interval counter
	psrf_interval u_interval
	(
		.mclk       (mclk),
		.rst        (rst),
		.enable     (refresh_on_bit),
		.restart    (interval_restart),
		.sel        (sel),
		.expired_ff (expired)
	); // R09

	////////////////////////////////////////////////////////////////////////
	// Register writes, byte and single bit
	always @*
	begin
		nxt_mode = refresh_mode_control_ff;
		nxt_area = refresh_area_select_ff;
		if (reg_wr && mode_hit)
			nxt_mode = reg_wdata & `PSRF_MODE_WMASK; // R03
		else if (reg_bit_wr && mode_hit)
		begin
			// Bit writes obey the same mask as byte writes
			nxt_mode[reg_bit_sel] = reg_bit_val; // R03
			nxt_mode = nxt_mode & `PSRF_MODE_WMASK;
		end
		// Area register takes all eight bits
		if (reg_wr && area_hit_reg)
			nxt_area = reg_wdata; // R05
		else if (reg_bit_wr && area_hit_reg)
			nxt_area[reg_bit_sel] = reg_bit_val;
		// Level bit reads back the real pin level
		if (!(reg_wr || reg_bit_wr) || !mode_hit)
			nxt_mode[`PSRF_LV_BIT] = refresh_mode_control_ff[`PSRF_LV_BIT];
	end

	// Register store and registered read port
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			refresh_mode_control_ff <= `PSRF_MODE_RST; // R02
			refresh_area_select_ff  <= `PSRF_AREA_RST; // R05
			reg_rdata_ff            <= 8'h00;
		end
		else
		begin
			refresh_mode_control_ff <= nxt_mode;
			refresh_area_select_ff  <= nxt_area;
			// Read data follows the address of the previous cycle
			if (mode_hit)
				reg_rdata_ff <= {level_ff,
					refresh_mode_control_ff[6:0]}; // R17
			else if (area_hit_reg)
				reg_rdata_ff <= refresh_area_select_ff;
			else
				reg_rdata_ff <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Refresh sequencer
	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
			begin
				// Self-refresh request wins over a due refresh
				if (refresh_on_bit && !refresh_pin_level_bit)
					nxt_state = ST_SELF; // R15
				else if (refresh_on_bit && (pend_ff || expired) &&
					!ext_req)
					nxt_state = ST_CYC; // R10
			end
			ST_CYC:
			begin
				// A started cycle runs to its end for a whole pulse
				if (cyc_cnt_ff == `PSRF_CYC_LEN - 2'h1)
					nxt_state = ST_IDLE;
			end
			ST_SELF:
			begin
				// Disable leaves at once; level one starts the exit
				if (!refresh_on_bit)
					nxt_state = ST_IDLE;
				else if (refresh_pin_level_bit)
					nxt_state = ST_EXIT;
			end
			ST_EXIT:
			begin
				// Pin rises on an interval expiry, or at once when refresh is disabled
				if (!refresh_on_bit || expired)
					nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// State and cycle length counter; the counter runs only in a cycle
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_ff   <= ST_IDLE;
			cyc_cnt_ff <= 2'h0;
		end
		else
		begin
			state_ff   <= nxt_state;
			cyc_cnt_ff <= (state_ff == ST_CYC) ?
				cyc_cnt_ff + 2'h1 : 2'h0;
		end
	end

	// Pending refresh held off by an access, cleared on service
	// A set and a clear in one clock leave the refresh pending
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
			pend_ff <= 1'b0;
		else if (!refresh_on_bit)
			pend_ff <= 1'b0; // R18
		else if (expired && ext_req)
			pend_ff <= 1'b1; // R10
		else if (nxt_state == ST_CYC || sim_pulse)
			pend_ff <= 1'b0; // R14
	end

	// Bus side: an access waits during a refresh cycle
	// Pin mode holds through a started cycle so the pulse ends whole
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ext_grant_ff        <= 1'b0;
			refresh_pin_mode_ff <= 1'b0; // R02
			refresh_busy_ff     <= 1'b0;
		end
		else
		begin
			ext_grant_ff <= ext_req && nxt_state != ST_CYC &&
				nxt_state != ST_SELF && nxt_state != ST_EXIT; // R10
			refresh_pin_mode_ff <= refresh_on_bit || (nxt_state == ST_CYC); // R18
			refresh_busy_ff     <= (nxt_state == ST_CYC); // R11
		end
	end

	// Pin: low pulse in a cycle or with the strobe, low in self-refresh
	// The strobe pulse lasts as long as the strobe is sampled high
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
			refresh_request_pin_n_ff <= 1'b1;
		else if (nxt_state == ST_SELF || nxt_state == ST_EXIT)
			refresh_request_pin_n_ff <= 1'b0; // R15 R16
		else if (nxt_state == ST_CYC)
			refresh_request_pin_n_ff <= 1'b0; // R01 R07 R12 R14
		else if (sim_pulse)
			refresh_request_pin_n_ff <= 1'b0; // R13
		else
			refresh_request_pin_n_ff <= 1'b1;
	end

	// Level reads one only after the pin has really risen
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
			level_ff <= 1'b0;
		else if (state_ff == ST_EXIT && nxt_state == ST_IDLE)
			level_ff <= 1'b1; // R17
		else if (nxt_state == ST_SELF)
			level_ff <= 1'b0;
		else if (state_ff == ST_IDLE)
			level_ff <= refresh_pin_level_bit;
	end

endmodule

`default_nettype wire

// ===== psrf_psram_model.sv
`timescale 1ns/1ps
`default_nettype none
// Memory side: flags a pulse inside the post-exit disabled time
module psrf_psram_model
(
	// Clock, reset and refresh pin
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic pin_n,
	input  wire logic pin_mode,
	// Status
	output var  logic bad_ff
);
	reg [7:0] low_ff;
	reg [7:0] hold_ff;
	// Low-time count, disabled window, violation flag
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			low_ff <= 8'h00;
			hold_ff <= 8'h00;
			bad_ff <= 1'b0;
		end
		else
		begin
			if (pin_n)
				low_ff <= 8'h00;
			else if (low_ff != 8'hFF)
				low_ff <= low_ff + 8'h01;
			if (pin_n && low_ff > 8'h04)
				hold_ff <= 8'h14;
			else if (hold_ff != 8'h00)
				hold_ff <= hold_ff - 8'h01;
			if (!pin_n && pin_mode && hold_ff != 8'h00)
				bad_ff <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== psrf_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "psrf_regs.vh"
module psrf_props
(
	// Watched ports
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [19:0] reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_bit_wr,
	input wire logic        ext_req,
	input wire logic [7:0]  reg_rdata_ff,
	input wire logic        ext_grant_ff,
	input wire logic        refresh_request_pin_n_ff,
	input wire logic        refresh_pin_mode_ff,
	input wire logic        refresh_busy_ff
);
	// Short aliases
	wire pn = refresh_request_pin_n_ff;
	wire bz = refresh_busy_ff;
	wire md = refresh_pin_mode_ff;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	a_busy_no_grant: assert property (bz |-> !ext_grant_ff)
		else $error("grant during refresh");
	a_port_pin_high: assert property (!md |-> pn)
		else $error("pin low in port mode");
	a_cycle_two_clk: assert property ($rose(bz) |=> bz ##1 !bz)
		else $error("refresh cycle length");
	a_wait_access: assert property ($rose(bz) |-> !$past(ext_req))
		else $error("refresh during access");
	a_busy_pin_low: assert property (bz |-> !pn)
		else $error("no pulse in refresh");
	a_off_no_cycle: assert property (!md |-> !bz)
		else $error("refresh while off");
	a_unmapped_zero: assert property ((reg_addr != `PSRF_MODE_ADDR &&
		reg_addr != `PSRF_AREA_ADDR) |=> reg_rdata_ff == 8'h00)
		else $error("unmapped read not zero");
	a_mode_by_write: assert property ($rose(md) |->
		$past(reg_wr || reg_bit_wr, 2))
		else $error("pin mode without write");
endmodule
bind psrf_refresh psrf_props psrf_props_i (.*);
`default_nettype wire

// ===== psrf_refresh_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "psrf_regs.vh"
module psrf_refresh_bench;
	reg         mclk = 0, rst = 1, reg_wr = 0, reg_bit_wr = 0;
	reg         reg_bit_val = 0, ext_req = 0, ext_strobe = 0, p;
	reg  [2:0]  reg_bit_sel = 0;
	reg  [7:0]  reg_wdata = 0, d, lim;
	reg  [19:0] reg_addr = 0, ext_addr = 0, a;
	wire [7:0]  reg_rdata_ff;
	wire        ext_grant_ff, refresh_busy_ff, refresh_pin_mode_ff;
	wire        refresh_request_pin_n_ff, bad_ff;
	wire        pn = refresh_request_pin_n_ff;
	integer     err_total = 0, comparisons = 0, i, n, t;
	psrf_refresh psrf_refresh_i (.*);
	psrf_psram_model psrf_psram_model_i (.mclk(mclk), .rst(rst),
		.pin_n(pn), .pin_mode(refresh_pin_mode_ff), .bad_ff(bad_ff));
	initial forever #5 mclk = ~mclk;
	task chk(input [63:0] nm, input [7:0] got, input [7:0] exp);
	begin
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			err_total = err_total + 1;
			$display("[FAIL] %0s exp %h got %h", nm, exp, got);
		end
	end
	endtask
	task wr(input [19:0] ad, input [7:0] v);
	begin
		@(posedge mclk);
		reg_addr <= ad;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	end
	endtask
	task bw(input [2:0] s);
	begin
		@(posedge mclk);
		reg_addr <= `PSRF_MODE_ADDR;
		reg_bit_sel <= s;
		reg_bit_val <= 1'b1;
		reg_bit_wr <= 1'b1;
		@(posedge mclk);
		reg_bit_wr <= 1'b0;
	end
	endtask
	task rd(input [19:0] ad);
	begin
		@(posedge mclk);
		reg_addr <= ad;
		@(posedge mclk);
		#1 d = reg_rdata_ff;
	end
	endtask
	task stb(input [19:0] ad);
	begin
		@(posedge mclk);
		ext_addr <= ad;
		ext_strobe <= 1'b1;
		@(posedge mclk);
		ext_strobe <= 1'b0;
		#1 p = pn;
		@(posedge mclk);
	end
	endtask
	// Cycles until the pin next falls
	task fall;
	begin
		t = 0;
		while (pn !== 1'b1 && t < 500)
		begin
			@(posedge mclk);
			#1 t = t + 1;
		end
		while (pn !== 1'b0 && t < 500)
		begin
			@(posedge mclk);
			#1 t = t + 1;
		end
	end
	endtask
	task conclude;
	begin
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		#400000;
		err_total = err_total + 1;
		conclude;
	end
	////////////////////////////////////////////////////////////////////
	// Main sequence; bus hold never used, all three interval lengths checked
	initial
	begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		rd(`PSRF_MODE_ADDR);
		chk("mode", d, 8'h00);
		rd(`PSRF_AREA_ADDR);
		chk("area", d, 8'h00);
		chk("pin", {7'h00, pn}, 8'h01);
		wr(`PSRF_MODE_ADDR, 8'h6C);
		rd(`PSRF_MODE_ADDR);
		chk("mask", d, 8'h00);
		wr(`PSRF_MODE_ADDR, 8'h03);
		rd(`PSRF_MODE_ADDR);
		chk("mode", d, 8'h03);
		wr(`PSRF_AREA_ADDR, 8'hA5);
		rd(`PSRF_AREA_ADDR);
		chk("area", d, 8'hA5);
		rd(20'h0FFCE);
		chk("unmap", d, 8'h00);
		for (i = 0; i < 3; i = i + 1)
		begin
			lim = 8'h20 << i;
			wr(`PSRF_MODE_ADDR, 8'h80 | i);
			bw(3'h4);
			fall;
			fall;
			chk("period", (t >= lim && t <= lim + 3), 8'h01);
			chk("pmode", refresh_pin_mode_ff, 8'h01);
		end
		@(posedge mclk);
		ext_req <= 1'b1;
		n = 0;
		for (i = 0; i < 200; i = i + 1)
		begin
			@(posedge mclk);
			#1 n = n + refresh_busy_ff;
		end
		chk("held", n, 8'h00);
		chk("grant", ext_grant_ff, 8'h01);
		@(posedge mclk);
		ext_req <= 1'b0;
		t = 0;
		while (refresh_busy_ff !== 1'b1 && t < 10)
		begin
			@(posedge mclk);
			#1 t = t + 1;
		end
		chk("pend", (t < 10), 8'h01);
		@(posedge mclk);
		ext_req <= 1'b1;
		for (n = 0; n < 8; n = n + 1)
		begin
			a = (n < 4) ? n * 20'h00400 : 20'h00400 << (n - 2);
			wr(`PSRF_AREA_ADDR, 8'h01 << n);
			stb(a);
			chk("inarea", p, 8'h01);
			wr(`PSRF_AREA_ADDR, 8'hFF ^ (8'h01 << n));
			stb(a);
			chk("simul", p, 8'h00);
		end
		ext_req <= 1'b0;
		wr(`PSRF_MODE_ADDR, 8'h10);
		repeat (3) @(posedge mclk);
		#1 chk("self", pn, 8'h00);
		wr(`PSRF_MODE_ADDR, 8'h90);
		rd(`PSRF_MODE_ADDR);
		if (pn === 1'b0)
			chk("lvlow", d, 8'h10);
		t = 0;
		while (pn !== 1'b1 && t < 500)
		begin
			@(posedge mclk);
			#1 t = t + 1;
		end
		chk("exit", (t <= 32), 8'h01);
		fall;
		chk("realign", t, 8'h20);
		rd(`PSRF_MODE_ADDR);
		chk("lvhigh", d, 8'h90);
		wr(`PSRF_MODE_ADDR, 8'h00);
		repeat (150) @(posedge mclk);
		#1 chk("off", {pn, refresh_pin_mode_ff}, 8'h02);
		chk("gap", bad_ff, 8'h00);
		conclude;
	end
endmodule
`default_nettype wire
